// ---- core/rsp_map.svh ----
// Offsets, field positions and reset values of the reset and power-down block
`ifndef RSP_MAP_SVH
`define RSP_MAP_SVH
`define RSP_ADDR_CTRL        12'h000
`define RSP_ADDR_STATUS      12'h004
`define RSP_ADDR_CPU         12'h008
`define RSP_ADDR_INT         12'h00c
`define RSP_ADDR_TMR         12'h010
`define RSP_ADDR_PERI        12'h014
`define RSP_ADDR_LCD         12'h018
`define RSP_ADDR_EVENT       12'h01c
`define RSP_PC_RST           13'h0000
`define RSP_SP_RST           3'h7
`define RSP_REGB_RST         4'h0
`define RSP_NIB_ZERO         4'h0
`define RSP_NIB_ONES         4'hf
`define RSP_CTRL_CANCEL_BIT  0
`define RSP_EV_KEEP_BIT      0
`define RSP_EV_ARM_BIT       1
`define RSP_EV_POF_BIT       2
`define RSP_EV_ENTER_RAM_HOLD_OP_BIT      3
`define RSP_EV_WAKE_BIT      4
`define RSP_EV_T5_BIT        5
`define RSP_EV_WDT_BIT       6
`define RSP_EV_PIN_BIT       7
`endif

// ---- core/rsp_pkg.sv ----
// Types of the reset and power-down block
package rsp_pkg;
	typedef enum logic [1:0] {
		RSP_RUN,
		RSP_CLOCK_SLEEP,
		RSP_RAM_HOLD
	} rsp_mode_t;
	typedef enum logic [1:0] {
		RSP_RSP_OKAY   = 2'h0,
		RSP_RSP_SLVERR = 2'h2
	} rsp_resp_t;
endpackage : rsp_pkg

// ---- core/rsp_top.sv ----
// Reset state, brownout gating and power-down sequencing with an AXI4-Lite register port
//Contract
// [RL1] Reset clears all program counter bits
// [RL2] Reset clears global interrupt enable
// [RL3] Reset zeroes interrupt enable control A
// [RL4] Reset zeroes interrupt select controls A, B, C
// [RL5] Reset clears timer one to five flags
// [RL6] Reset clears both watchdog flags
// [RL7] Reset sets watchdog arm flag
// [RL8] Reset clears prescaler run bit
// [RL9] Reset zeroes timer4 control
// [RL10] Reset zeroes LCD timer control
// [RL11] Reset clears serial done flag, mode
// [RL12] Reset clears conversion flag, three ADC controls
// [RL13] Reset: LCD control A zeros, B ones
// [RL14] Software initialises everything else itself
// [RL15] Active brownout below threshold forces reset
// [RL16] Running: brownout enabled only with pin high
// [RL17] Sleeping: brownout needs keep op and pin
// [RL18] Keep op latches once, repeats ignored
// [RL19] Keep setting cancellable without reset
// [RL20] Arm then sleep op picks mode
// [RL21] Sleep op without arm is no-op
// [RL22] Clock sleep keeps subclock, LCD, timer5
// [RL23] Reset: on-chip oscillator, stack ones, B cleared
// [RL24] Wakeup restarts at zero, power flag set
// [RL25] Cold start restarts, power flag cleared
// [RL26] RAM hold leaves only on external wakeup
`timescale 1ns/1ps
`include "rsp_map.svh"
module rsp_top (
	input  wire logic             aclk,                // System clock
	input  wire logic             aresetn,             // Synchronous reset, active low
	input  wire logic [11:0]      s_axi_awaddr,        // Write address
	input  wire logic             s_axi_awvalid,       // Write address valid
	output logic                  s_axi_awready,       // Write address ready
	input  wire logic [31:0]      s_axi_wdata,         // Write data
	input  wire logic [3:0]       s_axi_wstrb,         // Write strobes
	input  wire logic             s_axi_wvalid,        // Write data valid
	output logic                  s_axi_wready,        // Write data ready
	output rsp_pkg::rsp_resp_t    s_axi_bresp,         // Write response
	output logic                  s_axi_bvalid,        // Write response valid
	input  wire logic             s_axi_bready,        // Write response ready
	input  wire logic [11:0]      s_axi_araddr,        // Read address
	input  wire logic             s_axi_arvalid,       // Read address valid
	output logic                  s_axi_arready,       // Read address ready
	output logic [31:0]           s_axi_rdata,         // Read data
	output rsp_pkg::rsp_resp_t    s_axi_rresp,         // Read response
	output logic                  s_axi_rvalid,        // Read data valid
	input  wire logic             s_axi_rready,        // Read data ready
	input  wire logic             ext_reset_n,         // Reset pin, active low
	input  wire logic             brownout_enable_pin, // Brownout detector enable pin
	input  wire logic             supply_below_thresh, // Detector: supply under threshold
	input  wire logic             watchdog_reset,      // Watchdog reset request
	input  wire logic             keep_brownout_in_sleep_op, // Keep-detector instruction pulse
	input  wire logic             sleep_arm_op,        // Arm instruction pulse
	input  wire logic             enter_clock_sleep_op, // First power-down instruction pulse
	input  wire logic             enter_ram_hold_op,   // Second power-down instruction pulse
	input  wire logic             external_wakeup,     // External wakeup request
	input  wire logic             timer5_underflow,    // Timer 5 underflow
	output logic                  core_reset,          // System reset to the core
	output logic                  brownout_active,     // Detector enabled
	output rsp_pkg::rsp_mode_t    power_mode,          // Current power mode
	output logic                  main_osc_run,        // Main oscillator running
	output logic                  subclock_run,        // Sub-clock oscillator running
	output logic                  lcd_run,             // LCD display running
	output logic                  timer5_run,          // Timer 5 running
	output logic                  power_down_flag,     // Warm start indicator
	output logic [12:0]           program_counter,     // Restart address
	output logic [31:0]           core_state           // Reset values presented to the core
);
	import rsp_pkg::*;

	rsp_mode_t   mode_ff;
	logic        armed_ff;
	logic        keep_ff;
	logic        pflag_ff;
	logic        rst_ff;
	logic [12:0] pc_ff;
	logic        gie_ff;
	logic [3:0]  ie_a_ff;
	logic [3:0]  sel_a_ff;
	logic [3:0]  sel_b_ff;
	logic        sel_c_ff;
	logic [4:0]  tflags_ff;
	logic [1:0]  wdflags_ff;
	logic        wdarm_ff;
	logic        pres_ff;
	logic [3:0]  t4_ff;
	logic [3:0]  lcdt_ff;
	logic        sdone_ff;
	logic [3:0]  smode_ff;
	logic        cdone_ff;
	logic [3:0]  adc_a_ff;
	logic [3:0]  adc_b_ff;
	logic [3:0]  adc_c_ff;
	logic [3:0]  lcd_a_ff;
	logic [3:0]  lcd_b_ff;
	logic [2:0]  sp_ff;
	logic [3:0]  regb_ff;
	logic        onchip_osc_ff;
	logic        cancel_req;
	logic [7:0]  event_ff;
	logic        aw_ok;
	logic        w_ok;
	logic        do_write;
	logic        do_read;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        aw_have_ff;
	logic        w_have_ff;
	logic        bvalid_ff;
	logic        rvalid_ff;
	rsp_resp_t   bresp_ff;
	rsp_resp_t   rresp_ff;
	logic [31:0] rdata_ff;
	logic        brown_trip;
	logic        cold_start;
	logic        wake_start;

	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == `RSP_ADDR_CTRL) || (a == `RSP_ADDR_STATUS) || (a == `RSP_ADDR_CPU)
			|| (a == `RSP_ADDR_INT) || (a == `RSP_ADDR_TMR) || (a == `RSP_ADDR_PERI)
			|| (a == `RSP_ADDR_LCD) || (a == `RSP_ADDR_EVENT);
	endfunction : addr_known

	// Detector enable follows pin, mode and kept setting
	assign brownout_active = brownout_enable_pin && ((mode_ff == RSP_RUN) || keep_ff); // [RL16] [RL17]
	assign brown_trip      = brownout_active && supply_below_thresh; // [RL15]
	assign cold_start      = !ext_reset_n || watchdog_reset || brown_trip;
	// Clock sleep may wake on timer 5; RAM hold only on external wakeup
	assign wake_start      = ((mode_ff == RSP_CLOCK_SLEEP) && (external_wakeup || timer5_underflow))
		|| ((mode_ff == RSP_RAM_HOLD) && external_wakeup); // [RL26]

	// Sleep mode sequencing
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start)
		begin
			mode_ff  <= RSP_RUN;
			armed_ff <= 1'b0;
		end
		else if (wake_start)
		begin
			mode_ff  <= RSP_RUN;
			armed_ff <= 1'b0;
		end
		else if (mode_ff == RSP_RUN)
		begin
			if (enter_clock_sleep_op && armed_ff)
			begin
				mode_ff  <= RSP_CLOCK_SLEEP; // [RL20]
				armed_ff <= 1'b0;
			end
			else if (enter_ram_hold_op && armed_ff)
			begin
				mode_ff  <= RSP_RAM_HOLD; // [RL20]
				armed_ff <= 1'b0;
			end
			else if (sleep_arm_op)
				armed_ff <= 1'b1;
			else if (enter_clock_sleep_op || enter_ram_hold_op)
				armed_ff <= 1'b0; // [RL21]
		end
	end

	// Keep-detector latch: set once, cleared by software cancel
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start)
			keep_ff <= 1'b0;
		else if (keep_brownout_in_sleep_op && !keep_ff)
			keep_ff <= 1'b1; // [RL18]
		else if (cancel_req)
			keep_ff <= 1'b0; // [RL19]
	end

	// Start condition, restart address and reset pulse
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start)
		begin
			pflag_ff <= 1'b0; // [RL25]
			pc_ff    <= `RSP_PC_RST; // [RL1] [RL25]
			rst_ff   <= 1'b1;
		end
		else if (wake_start)
		begin
			pflag_ff <= 1'b1; // [RL24]
			pc_ff    <= `RSP_PC_RST; // [RL24]
			rst_ff   <= 1'b1;
		end
		else
			rst_ff   <= 1'b0;
	end

	// Interrupt start state; reloaded on warm start as well
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start || wake_start)
		begin
			gie_ff    <= 1'b0; // [RL2]
			ie_a_ff   <= `RSP_NIB_ZERO; // [RL3]
			sel_a_ff  <= `RSP_NIB_ZERO; // [RL4]
			sel_b_ff  <= `RSP_NIB_ZERO; // [RL4]
			sel_c_ff  <= 1'b0; // [RL4]
			tflags_ff <= 5'h00; // [RL5]
		end
	end

	// Watchdog start state; armed after every start
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start || wake_start)
		begin
			wdflags_ff <= 2'h0; // [RL6]
			wdarm_ff   <= 1'b1; // [RL7]
		end
	end

	// CPU registers and clock source
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start || wake_start)
		begin
			sp_ff         <= `RSP_SP_RST; // [RL23]
			regb_ff       <= `RSP_REGB_RST; // [RL23]
			onchip_osc_ff <= 1'b1; // [RL23]
		end
	end

	// Timer controls; kept across power down
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start)
		begin
			pres_ff <= 1'b0; // [RL8]
			t4_ff   <= `RSP_NIB_ZERO; // [RL9]
			lcdt_ff <= `RSP_NIB_ZERO; // [RL10]
		end
	end

	// Serial port start state
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start)
		begin
			sdone_ff <= 1'b0; // [RL11]
			smode_ff <= `RSP_NIB_ZERO; // [RL11]
		end
	end

	// Converter start state; result registers are not modelled
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start)
		begin
			cdone_ff <= 1'b0; // [RL12]
			adc_a_ff <= `RSP_NIB_ZERO; // [RL12]
			adc_b_ff <= `RSP_NIB_ZERO; // [RL12]
			adc_c_ff <= `RSP_NIB_ZERO; // [RL12]
		end
	end

	// LCD control start state
	always_ff @(posedge aclk)
	begin
		if (!aresetn || cold_start)
		begin
			lcd_a_ff <= `RSP_NIB_ZERO; // [RL13]
			lcd_b_ff <= `RSP_NIB_ONES; // [RL13]
		end
	end

	// Sticky event capture; set beats clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			event_ff <= 8'h00;
		else
			event_ff <= (do_write && awaddr_ff == `RSP_ADDR_EVENT && wstrb_ff[0]
				? event_ff & ~wdata_ff[7:0] : event_ff)
				| {!ext_reset_n, watchdog_reset, timer5_underflow, external_wakeup,
				enter_ram_hold_op, enter_clock_sleep_op, sleep_arm_op, keep_brownout_in_sleep_op};
	end

	assign core_reset      = rst_ff;
	assign power_mode      = mode_ff;
	assign main_osc_run    = (mode_ff != RSP_RAM_HOLD);
	assign subclock_run    = (mode_ff != RSP_RAM_HOLD); // [RL22]
	assign lcd_run         = (mode_ff != RSP_RAM_HOLD); // [RL22]
	assign timer5_run      = (mode_ff != RSP_RAM_HOLD); // [RL22]
	assign power_down_flag = pflag_ff;
	assign program_counter = pc_ff;
	assign core_state      = {onchip_osc_ff, sp_ff, regb_ff, wdarm_ff, wdflags_ff, tflags_ff,
		sel_c_ff, sel_b_ff, sel_a_ff, ie_a_ff, gie_ff, 2'h0};

	// AXI4-Lite write path: address and data taken in either order
	assign aw_ok         = s_axi_awvalid && s_axi_awready;
	assign w_ok          = s_axi_wvalid && s_axi_wready;
	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready  = !w_have_ff && !bvalid_ff;
	assign do_write      = aw_have_ff && w_have_ff && !bvalid_ff;
	assign cancel_req    = do_write && awaddr_ff == `RSP_ADDR_CTRL && wstrb_ff[0]
		&& wdata_ff[`RSP_CTRL_CANCEL_BIT];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awaddr_ff  <= 12'h000;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RSP_RSP_OKAY;
		end
		else
		begin
			if (aw_ok)
			begin
				aw_have_ff <= 1'b1;
				awaddr_ff  <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (w_ok)
			begin
				w_have_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= addr_known(awaddr_ff) ? RSP_RSP_OKAY : RSP_RSP_SLVERR;
			end
			else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// AXI4-Lite read path
	assign s_axi_arready = !rvalid_ff;
	assign do_read       = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= RSP_RSP_OKAY;
		end
		else if (do_read)
		begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= addr_known({s_axi_araddr[11:2], 2'h0}) ? RSP_RSP_OKAY : RSP_RSP_SLVERR;
			unique case ({s_axi_araddr[11:2], 2'h0})
				`RSP_ADDR_CTRL:   rdata_ff <= 32'h0000_0000;
				`RSP_ADDR_STATUS: rdata_ff <= {24'h00_0000, brownout_enable_pin, brownout_active,
					keep_ff, armed_ff, pflag_ff, rst_ff, mode_ff};
				`RSP_ADDR_CPU:    rdata_ff <= {19'h0_0000, pc_ff};
				`RSP_ADDR_INT:    rdata_ff <= core_state;
				`RSP_ADDR_TMR:    rdata_ff <= {23'h00_0000, lcdt_ff, t4_ff, pres_ff};
				`RSP_ADDR_PERI:   rdata_ff <= {14'h0000, adc_c_ff, adc_b_ff, adc_a_ff, cdone_ff,
					smode_ff, sdone_ff};
				`RSP_ADDR_LCD:    rdata_ff <= {24'h00_0000, lcd_b_ff, lcd_a_ff};
				`RSP_ADDR_EVENT:  rdata_ff <= {24'h00_0000, event_ff};
				default:          rdata_ff <= 32'h0000_0000;
			endcase
		end
		else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;

endmodule : rsp_top

// ---- dv/rsp_top_chk.sv ----
// Assertion checker for the reset and power-down block
`timescale 1ns/1ps
module rsp_top_chk (
	input wire logic          aclk,                 // Clock
	input wire logic          aresetn,              // Reset
	input wire logic          ext_reset_n,          // Pin reset
	input wire logic          brownout_enable_pin,  // Enable pin
	input wire logic          supply_below_thresh,  // Low supply
	input wire logic          watchdog_reset,       // Watchdog
	input wire logic          sleep_arm_op,         // Arm
	input wire logic          enter_clock_sleep_op, // Sleep
	input wire logic          enter_ram_hold_op,    // Hold
	input wire logic          external_wakeup,      // Wake
	input wire logic          core_reset,           // Reset out
	input wire logic          brownout_active,      // Detector on
	input rsp_pkg::rsp_mode_t power_mode,           // Mode
	input wire logic          subclock_run,         // Sub-clock
	input wire logic          lcd_run,              // LCD
	input wire logic          timer5_run,           // Timer 5
	input wire logic          power_down_flag,      // Warm flag
	input wire logic [12:0]   program_counter       // PC
);
	import rsp_pkg::*;
	logic arm_ff;
	wire cold = !ext_reset_n || watchdog_reset || (supply_below_thresh && brownout_active);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Arm tracker errs towards armed, except that an arm op together with a sleep op clears it while the block arms
	always_ff @(posedge aclk)
	begin
		if (!aresetn || enter_clock_sleep_op || enter_ram_hold_op) arm_ff <= 1'b0;
		else if (sleep_arm_op) arm_ff <= 1'b1;
	end
	sequence s_arm; power_mode == RSP_RUN && sleep_arm_op && !cold; endsequence
	sequence s_clk; enter_clock_sleep_op && !enter_ram_hold_op && !cold; endsequence
	sequence s_ram; enter_ram_hold_op && !enter_clock_sleep_op && !cold; endsequence
	a_arm_clock: assert property (s_arm ##1 s_clk |=> power_mode == RSP_CLOCK_SLEEP)
		else $error("no clock sleep after arm");
	a_arm_hold: assert property (s_arm ##1 s_ram |=> power_mode == RSP_RAM_HOLD)
		else $error("no RAM hold after arm");
	a_no_arm: assert property (power_mode == RSP_RUN && !arm_ff && !sleep_arm_op && !cold
		&& (enter_clock_sleep_op || enter_ram_hold_op) |=> power_mode == RSP_RUN)
		else $error("sleep without arm");
	a_hold_stays: assert property (power_mode == RSP_RAM_HOLD && !external_wakeup && !cold
		|=> power_mode == RSP_RAM_HOLD)
		else $error("left RAM hold without wakeup");
	a_warm_start: assert property (power_mode != RSP_RUN && external_wakeup && !cold
		|=> power_mode == RSP_RUN && power_down_flag && core_reset)
		else $error("bad warm start");
	a_cold_start: assert property (!ext_reset_n || watchdog_reset |=> core_reset && !power_down_flag)
		else $error("bad cold start");
	a_trip_reset: assert property (supply_below_thresh && brownout_active |=> core_reset)
		else $error("no reset on trip");
	a_pin_off: assert property (!brownout_enable_pin |-> !brownout_active)
		else $error("detector on with pin low");
	a_run_on: assert property (power_mode == RSP_RUN && brownout_enable_pin |-> brownout_active)
		else $error("detector off while running");
	a_sleep_keeps: assert property (power_mode == RSP_CLOCK_SLEEP
		|-> subclock_run && lcd_run && timer5_run)
		else $error("clock sleep stopped a unit");
	a_start_pc: assert property (core_reset |-> program_counter == 13'h0000)
		else $error("start address not zero");
endmodule : rsp_top_chk
bind rsp_top rsp_top_chk chk (.aclk, .aresetn, .ext_reset_n, .brownout_enable_pin, .supply_below_thresh,
	.watchdog_reset, .sleep_arm_op, .enter_clock_sleep_op, .enter_ram_hold_op, .external_wakeup,
	.core_reset, .brownout_active, .power_mode, .subclock_run, .lcd_run, .timer5_run,
	.power_down_flag, .program_counter);

// ---- dv/rsp_top_tb_top.sv ----
// Self-checking testbench for the reset and power-down block
`timescale 1ns/1ps
`include "rsp_map.svh"
module rsp_top_tb_top;
	import rsp_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, brownout_enable_pin = 1'b1;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, core_state, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	rsp_resp_t s_axi_bresp, s_axi_rresp;
	logic [2:0] cr = '0;
	logic [5:0] ops = '0;
	wire ext_reset_n, supply_below_thresh, watchdog_reset, keep_brownout_in_sleep_op, sleep_arm_op;
	wire enter_clock_sleep_op, enter_ram_hold_op, external_wakeup, timer5_underflow;
	logic core_reset, brownout_active, main_osc_run, subclock_run, lcd_run, timer5_run, power_down_flag;
	rsp_mode_t power_mode;
	logic [12:0] program_counter;
	logic [1:0] r;
	int bad_count = 0, tests_run = 0, cyc = 0;
	assign ext_reset_n = !cr[1];
	assign watchdog_reset = cr[0];
	assign supply_below_thresh = cr[2];
	assign {timer5_underflow, external_wakeup, enter_ram_hold_op, enter_clock_sleep_op, sleep_arm_op,
		keep_brownout_in_sleep_op} = ops;
	rsp_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.ext_reset_n, .brownout_enable_pin, .supply_below_thresh, .watchdog_reset,
		.keep_brownout_in_sleep_op, .sleep_arm_op, .enter_clock_sleep_op, .enter_ram_hold_op,
		.external_wakeup, .timer5_underflow, .core_reset, .brownout_active, .power_mode, .main_osc_run,
		.subclock_run, .lcd_run, .timer5_run, .power_down_flag, .program_counter, .core_state);
	always #4 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	// Two instruction cycles back to back, then settle
	task automatic pulse(input logic [5:0] v, w);
		@(posedge aclk);
		ops <= v;
		@(posedge aclk);
		ops <= w;
		@(posedge aclk);
		ops <= '0;
		@(posedge aclk);
		#1;
	endtask : pulse
	task automatic cold(input logic [2:0] v);
		@(posedge aclk);
		cr <= v;
		@(posedge aclk);
		cr <= '0;
		#1;
		chk("core_reset", 1, core_reset);
		chk("power_down_flag", 0, power_down_flag);
	endtask : cold
	function automatic logic [31:0] exp_reg(input int i);
		case (i)
			1: return {1'b1, `RSP_SP_RST, `RSP_REGB_RST, 1'b1, 2'h0, 5'h00, 1'b0, 12'h000, 1'b0, 2'h0};
			4: return {24'h000000, `RSP_NIB_ONES, `RSP_NIB_ZERO};
			default: return 32'h00000000;
		endcase
	endfunction : exp_reg
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	initial
	begin
		void'($urandom(26));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`RSP_ADDR_CPU);
		chk("pc reset", exp_reg(0), d);
		rd(`RSP_ADDR_INT);
		chk("int reset", exp_reg(1), d);
		rd(`RSP_ADDR_TMR);
		chk("timer reset", exp_reg(2), d);
		rd(`RSP_ADDR_PERI);
		chk("peripheral reset", exp_reg(3), d);
		rd(`RSP_ADDR_LCD);
		chk("lcd reset", exp_reg(4), d);
		chk("core_state", exp_reg(1), core_state);
		chk("program_counter", 0, program_counter);
		rd(12'h100);
		chk("unmapped resp", RSP_RSP_SLVERR, r);
		pulse(6'h04, 6'h00);
		chk("mode", RSP_RUN, power_mode);
		pulse(6'h01, 6'h01);
		rd(`RSP_ADDR_STATUS);
		chk("keep latch", 1, d[5]);
		pulse(6'h02, 6'h04);
		chk("mode", RSP_CLOCK_SLEEP, power_mode);
		chk("detector", 1, brownout_active);
		chk("sleep units", 3'h7, {subclock_run, lcd_run, timer5_run});
		pulse(6'h20, 6'h00);
		chk("mode", RSP_RUN, power_mode);
		chk("power_down_flag", 1, power_down_flag);
		rd(`RSP_ADDR_CPU);
		chk("pc", 0, d);
		wr(`RSP_ADDR_CTRL, 32'h1);
		chk("write resp", RSP_RSP_OKAY, r);
		rd(`RSP_ADDR_STATUS);
		chk("keep latch", 0, d[5]);
		cold(3'h1);
		pulse(6'h02, 6'h08);
		chk("mode", RSP_RAM_HOLD, power_mode);
		chk("detector", 0, brownout_active);
		chk("main_osc_run", 0, main_osc_run);
		pulse(6'h20, 6'h00);
		chk("mode", RSP_RAM_HOLD, power_mode);
		pulse(6'h10, 6'h00);
		chk("mode", RSP_RUN, power_mode);
		chk("power_down_flag", 1, power_down_flag);
		cold(3'h2);
		rd(`RSP_ADDR_EVENT);
		chk("events", 32'h0000_00ff, d);
		wr(`RSP_ADDR_EVENT, 32'h0000_00ff);
		rd(`RSP_ADDR_EVENT);
		chk("events cleared", 32'h0000_0000, d);
		repeat (16)
		begin
			@(posedge aclk);
			brownout_enable_pin <= 1'($urandom);
			@(posedge aclk);
			#1;
			chk("detector", brownout_enable_pin, brownout_active);
		end
		@(posedge aclk);
		brownout_enable_pin <= 1'b1;
		cold(3'h4);
		complete_run();
	end
endmodule : rsp_top_tb_top
